/* File: hw/ppom_cfg.svh */
// reset values and sizes for the port pin override mux
// assumes inclusion by ppom_pkg and ppom_top only
`ifndef PPOM_CFG_SVH
`define PPOM_CFG_SVH

`define PPOM_PIN_COUNT 8
`define PPOM_DIR_RESET 8'h00
`define PPOM_LVL_RESET 8'h00
`define PPOM_SYNC_RESET 8'h00
`define PPOM_TIE_LOW 8'h00
`define PPOM_SYNC_STAGES 2

`endif

/* File: hw/ppom_pkg.sv */
// types shared by the port pin override mux
// assumes ppom_cfg.svh sits beside it
`include "ppom_cfg.svh"

package ppom_pkg;

	typedef logic [`PPOM_PIN_COUNT-1:0] ppom_byte_t;

	// per-pin override bundle, one bit per pin in each field
	typedef struct packed {
		ppom_byte_t pullup_override_enable;
		ppom_byte_t pullup_override_value;
		ppom_byte_t driver_override_enable;
		ppom_byte_t driver_override_value;
		ppom_byte_t level_override_enable;
		ppom_byte_t level_override_value;
		ppom_byte_t toggle_override_enable;
		ppom_byte_t input_gate_override_enable;
		ppom_byte_t input_gate_override_value;
	} ppom_ovr_t;

	// pad-side controls for the eight pins
	typedef struct packed {
		ppom_byte_t drive_en;
		ppom_byte_t drive_val;
		ppom_byte_t pullup_en;
		ppom_byte_t input_en;
	} ppom_pad_ctl_t;

endpackage : ppom_pkg

/* File: hw/ppom_top.sv */
// port A pin control with alternate-function override selection
// assumes pad inputs already pass a schmitt trigger and are
// asynchronous to mclk_i; analog lines are joined at the pad ring
`timescale 1ns/10ps

`include "ppom_cfg.svh"

// Summary of operation
// - pull-up follows override, else direction/level/disable 010
// - enabled pull-up override ignores register bits
// - driver enable from override, else direction bit
// - enabled driver override ignores direction bit
// - driven level from override, else level bit
// - enabled level override ignores level bit
// - toggle override inverts stored level bit
// - input gate from override, else chip state
// - enabled input gate override ignores sleep
// - raw tap after schmitt, before synchroniser
// - analog line straight to pad
// - overrides come from alternate-function modules
// - strobes per port, sleep/disable/clock shared
// - port A pull/driver/level overrides tied low
// - input gate override from mask, group, disable
// - tap feeds pin change, pad feeds converter
// - every pin is a pin change source
// - direction one is output, zero input
// - sleep clamps input without override
module ppom_top
(
	input  wire logic                mclk_i,
	input  wire logic                reset_n_i,
	input  wire logic                dir_wr_i,
	input  wire ppom_pkg::ppom_byte_t dir_wdata_i,
	input  wire logic                lvl_wr_i,
	input  wire ppom_pkg::ppom_byte_t lvl_wdata_i,
	input  wire logic                tgl_wr_i,
	input  wire ppom_pkg::ppom_byte_t tgl_wdata_i,
	input  wire logic                sleep_i,
	input  wire logic                global_pullup_off_i,
	input  wire ppom_pkg::ppom_byte_t pin_change_mask_bits_i,
	input  wire logic                pin_change_group0_enable_i,
	input  wire ppom_pkg::ppom_byte_t analog_input_disable_bits_i,
	input  wire ppom_pkg::ppom_byte_t pad_in_i,
	input  wire ppom_pkg::ppom_byte_t analog_pad_line_i,
	output var  ppom_pkg::ppom_byte_t pin_direction_bit_o,
	output var  ppom_pkg::ppom_byte_t output_level_bit_o,
	output var  ppom_pkg::ppom_byte_t pin_value_o,
	output var  ppom_pkg::ppom_byte_t raw_pin_input_tap_o,
	output var  ppom_pkg::ppom_byte_t analog_pad_line_o,
	output var  ppom_pkg::ppom_byte_t pad_out_o,
	output var  ppom_pkg::ppom_byte_t pad_oe_o,
	output var  ppom_pkg::ppom_byte_t pad_pullup_o,
	output var  ppom_pkg::ppom_byte_t input_enable_o
);
	import ppom_pkg::*;

	ppom_byte_t    pin_direction_bit;
	ppom_byte_t    next_pin_direction_bit;
	ppom_byte_t    output_level_bit;
	ppom_byte_t    next_output_level_bit;
	ppom_byte_t    sync_meta;
	ppom_byte_t    next_sync_meta;
	ppom_byte_t    sync_out;
	ppom_byte_t    next_sync_out;
	ppom_ovr_t     ovr;
	ppom_pad_ctl_t pad_ctl;
	ppom_byte_t    raw_tap;

	// selects override value when enabled, else default
	function automatic ppom_byte_t ppom_pick
	(
		input ppom_byte_t en,
		input ppom_byte_t val,
		input ppom_byte_t dflt
	);
		ppom_pick = (en & val) | (~en & dflt);
	endfunction : ppom_pick

	// port A override mapping from the owning modules' controls
	function automatic ppom_ovr_t ppom_port_a_map
	(
		input ppom_byte_t mask,
		input logic       group_en,
		input ppom_byte_t an_dis
	);
		ppom_byte_t pc_term;
		pc_term = mask & {`PPOM_PIN_COUNT{group_en}};
		ppom_port_a_map.pullup_override_enable = `PPOM_TIE_LOW;
		ppom_port_a_map.pullup_override_value  = `PPOM_TIE_LOW;
		ppom_port_a_map.driver_override_enable = `PPOM_TIE_LOW;
		ppom_port_a_map.driver_override_value  = `PPOM_TIE_LOW;
		ppom_port_a_map.level_override_enable  = `PPOM_TIE_LOW;
		ppom_port_a_map.level_override_value   = `PPOM_TIE_LOW;
		ppom_port_a_map.toggle_override_enable = `PPOM_TIE_LOW;
		ppom_port_a_map.input_gate_override_enable = pc_term | an_dis;
		ppom_port_a_map.input_gate_override_value  = pc_term;
	endfunction : ppom_port_a_map

	always_comb
	begin
		ovr = ppom_port_a_map(pin_change_mask_bits_i, pin_change_group0_enable_i,
			analog_input_disable_bits_i);
	end

	// one strobe set for the whole port
	always_comb
	begin
		next_pin_direction_bit = pin_direction_bit;
		next_output_level_bit  = output_level_bit;
		if (dir_wr_i)
		begin
			next_pin_direction_bit = dir_wdata_i;
		end
		if (lvl_wr_i)
		begin
			next_output_level_bit = lvl_wdata_i;
		end
		else
		begin
			next_output_level_bit = output_level_bit ^
				((tgl_wdata_i & {`PPOM_PIN_COUNT{tgl_wr_i}}) | ovr.toggle_override_enable);
		end
	end

	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			pin_direction_bit <= `PPOM_DIR_RESET;
			output_level_bit  <= `PPOM_LVL_RESET;
		end
		else
		begin
			pin_direction_bit <= next_pin_direction_bit;
			output_level_bit  <= next_output_level_bit;
		end
	end

	// per-pin selection, no register in path
	genvar gi;
	generate
		for (gi = 0; gi < `PPOM_PIN_COUNT; gi++)
		begin : g_pin
			assign pad_ctl.pullup_en[gi] = ovr.pullup_override_enable[gi] ?
				ovr.pullup_override_value[gi] :
				(!pin_direction_bit[gi] && output_level_bit[gi] && !global_pullup_off_i);
			assign pad_ctl.input_en[gi] = ovr.input_gate_override_enable[gi] ?
				ovr.input_gate_override_value[gi] : !sleep_i;
			assign raw_tap[gi] = pad_in_i[gi] & pad_ctl.input_en[gi];
		end
	endgenerate

	assign pad_ctl.drive_en = ppom_pick(ovr.driver_override_enable,
		ovr.driver_override_value, pin_direction_bit);
	assign pad_ctl.drive_val = pad_ctl.drive_en & ppom_pick(ovr.level_override_enable,
		ovr.level_override_value, output_level_bit);

	// two-stage synchroniser ahead of the pin value
	always_comb
	begin
		next_sync_meta = raw_tap;
		next_sync_out  = sync_meta;
	end

	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			sync_meta <= `PPOM_SYNC_RESET;
			sync_out  <= `PPOM_SYNC_RESET;
		end
		else
		begin
			sync_meta <= next_sync_meta;
			sync_out  <= next_sync_out;
		end
	end

	// tap doubles as pin change input
	assign raw_pin_input_tap_o = raw_tap;
	assign analog_pad_line_o   = analog_pad_line_i;
	assign pin_direction_bit_o = pin_direction_bit;
	assign output_level_bit_o  = output_level_bit;
	assign pin_value_o         = sync_out;
	// direction bit drives the output enable
	assign pad_oe_o            = pad_ctl.drive_en;
	assign pad_out_o           = pad_ctl.drive_val;
	assign pad_pullup_o        = pad_ctl.pullup_en;
	assign input_enable_o      = pad_ctl.input_en;

	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!reset_n_i);

	sequence s_toggle_req;
		tgl_wr_i && !lvl_wr_i && !dir_wr_i;
	endsequence

	sequence s_level_flipped;
		output_level_bit == ($past(output_level_bit) ^ $past(tgl_wdata_i));
	endsequence

	sequence s_tap_seen;
		##2 pin_value_o == $past(raw_pin_input_tap_o, 2);
	endsequence

	a_pullup_default:
	assert property (pad_pullup_o ==
		(~pin_direction_bit_o & output_level_bit_o & {`PPOM_PIN_COUNT{!global_pullup_off_i}}))
	else $error("pull-up differs from register combination");

	a_pullup_override:
	assert property (pad_pullup_o ==
		((ovr.pullup_override_value & ovr.pullup_override_enable) | (~ovr.pullup_override_enable &
		~pin_direction_bit_o & output_level_bit_o & {`PPOM_PIN_COUNT{!global_pullup_off_i}})))
	else $error("pull-up ignores its override");

	a_driver_select:
	assert property (pad_oe_o == pin_direction_bit_o)
	else $error("driver enable not from direction bit");

	a_driver_override:
	assert property (pad_oe_o ==
		((ovr.driver_override_value & ovr.driver_override_enable) |
		(~ovr.driver_override_enable & pin_direction_bit_o)))
	else $error("driver enable ignores its override");

	a_level_driven:
	assert property (pad_out_o == (pad_oe_o & output_level_bit_o))
	else $error("driven level not from level bit");

	a_level_override:
	assert property (pad_out_o == (pad_oe_o &
		((ovr.level_override_value & ovr.level_override_enable) |
		(~ovr.level_override_enable & output_level_bit_o))))
	else $error("driven level ignores its override");

	a_toggle_flip:
	assert property (s_toggle_req |=> s_level_flipped)
	else $error("toggle strobe did not invert level bits");

	a_gate_default:
	assert property (((input_enable_o ^ {`PPOM_PIN_COUNT{!sleep_i}}) &
		~ovr.input_gate_override_enable) == `PPOM_TIE_LOW)
	else $error("input gate not from chip state");

	a_gate_override:
	assert property ((input_enable_o & ovr.input_gate_override_enable) ==
		(ovr.input_gate_override_value & ovr.input_gate_override_enable))
	else $error("input gate ignores its override");

	a_tap_sync_path:
	assert property (##2 1 |-> pin_value_o == $past(pad_in_i & input_enable_o, 2))
	else $error("pin value not two cycles behind tap");

	a_tap_latency:
	assert property ($changed(raw_pin_input_tap_o) |-> s_tap_seen)
	else $error("synchronised value late or wrong");

	a_analog_pass:
	assert property (analog_pad_line_o == analog_pad_line_i)
	else $error("analog line altered");

	a_port_a_gate:
	assert property (ovr.input_gate_override_enable ==
		((pin_change_mask_bits_i & {`PPOM_PIN_COUNT{pin_change_group0_enable_i}})
		| analog_input_disable_bits_i))
	else $error("port A input gate mapping wrong");

	a_sleep_clamp:
	assert property (sleep_i && analog_input_disable_bits_i == `PPOM_TIE_LOW
		&& !pin_change_group0_enable_i |-> raw_pin_input_tap_o == `PPOM_TIE_LOW)
	else $error("sleep did not clamp digital input");

	a_dir_write:
	assert property (dir_wr_i |=> pin_direction_bit_o == $past(dir_wdata_i)
		&& pad_oe_o == $past(dir_wdata_i))
	else $error("direction write did not steer driver");

	a_same_cycle:
	assert property ($changed(pin_change_mask_bits_i & {`PPOM_PIN_COUNT{pin_change_group0_enable_i}})
		|-> (input_enable_o & pin_change_mask_bits_i & {`PPOM_PIN_COUNT{pin_change_group0_enable_i}}) ==
		(pin_change_mask_bits_i & {`PPOM_PIN_COUNT{pin_change_group0_enable_i}}))
	else $error("override not applied in same cycle");

endmodule : ppom_top

/* File: verification/ppom_alt_model.sv */
// alternate-function side: pin change logic and converter input
// assumes the bench hands its settings over at the falling edge
`timescale 1ns/10ps

module ppom_alt_model
(
	input  wire logic                  mclk_i,
	input  wire logic                  reset_n_i,
	input  wire ppom_pkg::ppom_byte_t  cfg_mask_i,
	input  wire logic                  cfg_grp_i,
	input  wire ppom_pkg::ppom_byte_t  cfg_adis_i,
	input  wire ppom_pkg::ppom_byte_t  raw_tap_i,
	input  wire ppom_pkg::ppom_byte_t  analog_i,
	output var   ppom_pkg::ppom_byte_t mask_o,
	output logic                       grp_o,
	output var   ppom_pkg::ppom_byte_t adis_o,
	output var   ppom_pkg::ppom_byte_t pc_sync_o,
	output var   ppom_pkg::ppom_byte_t adc_o
);
	import ppom_pkg::*;

	ppom_byte_t meta;

	assign mask_o = cfg_mask_i;
	assign grp_o  = cfg_grp_i;
	assign adis_o = cfg_adis_i;
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			meta      <= 8'h00;
			pc_sync_o <= 8'h00;
		end
		else
		begin
			meta      <= raw_tap_i;
			pc_sync_o <= meta;
		end
	end
	// converter channel n from pad line n
	assign adc_o = analog_i;
endmodule : ppom_alt_model

/* File: verification/tb_top.sv */
// random bench for the port pin override mux
// assumes ppom_pkg is compiled first
`timescale 1ns/10ps

module tb_top;
	import ppom_pkg::*;

	logic       mclk_i, reset_n_i, dir_wr, lvl_wr, tgl_wr, sleep, gpo, grp_c, grp;
	ppom_byte_t dir_wd, lvl_wd, tgl_wd, mask_c, adis_c, pad_in, ana, mask, adis;
	ppom_byte_t dir_o, lvl_o, pv_o, tap_o, ana_o, out_o, oe_o, pu_o, ie_o, pc_sync, adc;
	ppom_byte_t m_dir, m_lvl;
	ppom_byte_t m_sq[$];
	int         num_errors, comparisons, seed;

	ppom_top dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .dir_wr_i(dir_wr), .dir_wdata_i(dir_wd),
		.lvl_wr_i(lvl_wr), .lvl_wdata_i(lvl_wd), .tgl_wr_i(tgl_wr), .tgl_wdata_i(tgl_wd),
		.sleep_i(sleep), .global_pullup_off_i(gpo), .pin_change_mask_bits_i(mask),
		.pin_change_group0_enable_i(grp), .analog_input_disable_bits_i(adis), .pad_in_i(pad_in),
		.analog_pad_line_i(ana), .pin_direction_bit_o(dir_o), .output_level_bit_o(lvl_o),
		.pin_value_o(pv_o), .raw_pin_input_tap_o(tap_o), .analog_pad_line_o(ana_o),
		.pad_out_o(out_o), .pad_oe_o(oe_o), .pad_pullup_o(pu_o), .input_enable_o(ie_o));

	ppom_alt_model alt (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .cfg_mask_i(mask_c), .cfg_grp_i(grp_c),
		.cfg_adis_i(adis_c), .raw_tap_i(tap_o), .analog_i(ana_o), .mask_o(mask), .grp_o(grp),
		.adis_o(adis), .pc_sync_o(pc_sync), .adc_o(adc));

	function automatic ppom_byte_t ie_f();
		ppom_byte_t hit;
		ppom_byte_t ovr;
		hit = mask_c & {8{grp_c}};
		ovr = hit | adis_c;
		return (ovr & hit) | (~ovr & {8{~sleep}});
	endfunction : ie_f

	task automatic chk(input string nm, input ppom_byte_t e, input ppom_byte_t g);
		comparisons++;
		if (g !== e)
		begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic check_all();
		chk("pad_oe", m_dir, oe_o);
		chk("pad_out", m_dir & m_lvl, out_o);
		chk("pullup", ~m_dir & m_lvl & {8{~gpo}}, pu_o);
		chk("level", m_lvl, lvl_o);
		chk("direction", m_dir, dir_o);
		chk("input_en", ie_f(), ie_o);
		chk("tap", pad_in & ie_f(), tap_o);
		chk("pin_value", m_sq[0], pv_o);
		chk("pc_sync", m_sq[0], pc_sync);
		chk("analog", ana, adc);
	endtask : check_all

	task automatic drive();
		{dir_wr, lvl_wr, tgl_wr, sleep, gpo, grp_c} = 6'($urandom);
		{dir_wd, lvl_wd, tgl_wd, mask_c} = $urandom;
		{adis_c, pad_in, ana} = 24'($urandom);
		adis_c = adis_c & 8'($urandom);
		if (dir_wr)
			m_dir = dir_wd;
		if (lvl_wr)
			m_lvl = lvl_wd;
		else if (tgl_wr)
			m_lvl = m_lvl ^ tgl_wd;
		void'(m_sq.pop_front());
		m_sq.push_back(pad_in & ie_f());
	endtask : drive

	task automatic rst_seq(input int n);
		{dir_wr, lvl_wr, tgl_wr} = 3'h0;
		reset_n_i = 1'b0;
		{m_dir, m_lvl} = 16'h0;
		m_sq.delete();
		m_sq.push_back(8'h00);
		#1;
		chk("reset_oe", 8'h00, oe_o);
		repeat (n) @(negedge mclk_i);
		reset_n_i = 1'b1;
		m_sq.push_back(pad_in & ie_f());
	endtask : rst_seq

	task automatic run(input int n);
		repeat (n)
		begin
			@(negedge mclk_i);
			check_all();
			drive();
		end
	endtask : run

	task automatic conclude();
		$display("checks %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : conclude

	initial
	begin
		mclk_i = 1'b0;
		forever #2 mclk_i = ~mclk_i;
	end

	initial
	begin
		num_errors = 0;
		comparisons = 0;
		seed = $urandom(32'h06D4);
		{sleep, gpo, grp_c, dir_wd, lvl_wd, tgl_wd, mask_c, adis_c, pad_in, ana} = 59'h0;
		rst_seq(16);
		run(600);
		@(negedge mclk_i);
		rst_seq(3);
		run(200);
		conclude();
	end
endmodule : tb_top
